// file: hdl/decode_map.svh
// Constant map of the branch and system-control decoder: opcode fields,
// match patterns, cycle counts and reset values.
// Assumes 16-bit instruction words, most significant bit first.
`ifndef DECODE_MAP_SVH
`define DECODE_MAP_SVH

// Fixed opcode patterns (whole word)
`define OPC_SUB_RETURN 16'h000b
`define OPC_EXC_RETURN 16'h002b
`define OPC_SLEEP 16'h001b
`define OPC_CLEAR_FLAG 16'h0008
`define OPC_SET_FLAG 16'h0018
`define OPC_NOP 16'h0009
// Top byte patterns of conditional branches
`define OPC_BR_CLEAR 8'h8b
`define OPC_BR_SET 8'h89
`define OPC_BR_CLEAR_DLY 8'h8f
`define OPC_BR_SET_DLY 8'h8d
// Top nibble of pc-relative branches
`define OPC_BRANCH 4'ha
`define OPC_BRANCH_SUB 4'hb
// Register-form low bytes, with top nibble 4'h0 or 4'h4
`define OPC_JUMP_LO 8'h2b
`define OPC_JUMP_SUB_LO 8'h0b
`define OPC_PREFETCH_LO 8'h83
`define OPC_LDC_LO 8'h0e
`define OPC_LDS_LO 8'h0a
`define OPC_STC_LO 8'h02
`define OPC_STS_LO 8'h0a
`define OPC_BRAF_LO 8'h23
`define OPC_BSRF_LO 8'h03

// Minimum cycle counts
`define CYC_BRANCH_TAKEN 3'd3
`define CYC_BRANCH_DLY 3'd2
`define CYC_EXC_RETURN 3'd5
`define CYC_SLEEP 3'd4
`define CYC_ONE 3'd1
`define CYC_CONTENTION 3'd1
`define CYC_LOAD_USE 3'd1

// Displacement scale shifts
`define SHIFT_BYTE 2'd0
`define SHIFT_WORD 2'd1
`define SHIFT_LONG 2'd2

`define RESET_FLAG 1'b0
`define RESET_ADDR 32'h00000000

`endif

// file: hdl/decode_pkg.sv
// Types shared by the decoder files.
// Assumes nothing beyond the constant map.
package decode_pkg;

  typedef enum logic [4:0] {
    op_none,
    op_branch_if_flag_clear,
    op_branch_if_flag_set,
    op_branch,
    op_branch_sub,
    op_jump,
    op_jump_sub,
    op_sub_return,
    op_exception_return,
    op_sleep,
    op_cache_prefetch_instr,
    op_load_control_reg_instr,
    op_load_system_reg_instr,
    op_store_control_reg_instr,
    op_store_system_reg_instr,
    op_clear_flag,
    op_set_flag,
    op_branch_far,
    op_branch_sub_far,
    op_nop
  } op_class_t;

  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } op_size_t;

  typedef enum {
    st_run,
    st_stall,
    st_sleep
  } issue_state_t;

endpackage

// file: hdl/decode_if.sv
// Carries one decoded instruction from field decode to issue.
// Assumes both ends sit on the same core clock.
`timescale 1ns/10ps
interface decode_if;
  import decode_pkg::*;
  op_class_t op;
  logic [3:0] src_idx;
  logic [3:0] dst_idx;
  logic [31:0] disp_scaled;
  logic reads_src;
  logic reads_dst;
  modport producer (output op, src_idx, dst_idx, disp_scaled, reads_src,
    reads_dst);
  modport consumer (input op, src_idx, dst_idx, disp_scaled, reads_src,
    reads_dst);
endinterface

// file: hdl/field_decode.sv
// Combinational field decoder: class, register indices, scaled displacement.
// Assumes a stable 16-bit instruction word on the same clock.
`timescale 1ns/10ps
`include "decode_map.svh"
module field_decode
  import decode_pkg::*;
(
  input wire logic [15:0] instr,
  decode_if.producer dec
);

  op_class_t op;
  logic [3:0] hi;
  logic [7:0] lo;
  logic [31:0] disp;
  op_size_t size;

  assign hi = instr[15:12];
  assign lo = instr[7:0];

  always_comb begin
    op = op_none;
    disp = 32'h00000000;
    size = size_word;
    if (instr == `OPC_SUB_RETURN) begin
      op = op_sub_return;
    end else if (instr == `OPC_EXC_RETURN) begin
      op = op_exception_return;
    end else if (instr == `OPC_SLEEP) begin
      op = op_sleep;
    end else if (instr == `OPC_CLEAR_FLAG) begin
      op = op_clear_flag;
    end else if (instr == `OPC_SET_FLAG) begin
      op = op_set_flag;
    end else if (instr == `OPC_NOP) begin
      op = op_nop;
    end else if (instr[15:8] == `OPC_BR_CLEAR ||
        instr[15:8] == `OPC_BR_CLEAR_DLY) begin
      op = op_branch_if_flag_clear;
      disp = {{24{lo[7]}}, lo};
    end else if (instr[15:8] == `OPC_BR_SET ||
        instr[15:8] == `OPC_BR_SET_DLY) begin
      op = op_branch_if_flag_set;
      disp = {{24{lo[7]}}, lo};
    end else if (hi == `OPC_BRANCH) begin
      op = op_branch;
      disp = {{20{instr[11]}}, instr[11:0]};
    end else if (hi == `OPC_BRANCH_SUB) begin
      op = op_branch_sub;
      disp = {{20{instr[11]}}, instr[11:0]};
    end else if (hi == 4'h4) begin
      if (lo == `OPC_JUMP_LO) op = op_jump;
      else if (lo == `OPC_JUMP_SUB_LO) op = op_jump_sub;
      else if (lo == `OPC_LDC_LO) op = op_load_control_reg_instr;
      else if (lo == `OPC_LDS_LO) op = op_load_system_reg_instr;
    end else if (hi == 4'h0) begin
      if (lo == `OPC_PREFETCH_LO) op = op_cache_prefetch_instr;
      else if (lo == `OPC_STC_LO) op = op_store_control_reg_instr;
      else if (lo == `OPC_STS_LO) op = op_store_system_reg_instr;
      else if (lo == `OPC_BRAF_LO) op = op_branch_far;
      else if (lo == `OPC_BSRF_LO) op = op_branch_sub_far;
    end
  end

  // Branch displacements count in 16-bit words
  always_comb begin
    dec.op = op;
    dec.src_idx = instr[11:8];
    dec.dst_idx = instr[11:8];
    case (size)
      size_byte: dec.disp_scaled = disp << `SHIFT_BYTE;
      size_word: dec.disp_scaled = disp << `SHIFT_WORD;
      size_long: dec.disp_scaled = disp << `SHIFT_LONG;
      default: dec.disp_scaled = disp;
    endcase
    dec.reads_src = (op == op_jump) || (op == op_jump_sub) ||
      (op == op_load_control_reg_instr) || (op == op_load_system_reg_instr) ||
      (op == op_branch_far) || (op == op_branch_sub_far) ||
      (op == op_cache_prefetch_instr);
    dec.reads_dst = 1'b0;
  end

endmodule

// file: hdl/branch_sysctl_decode.sv
// Issue logic for branch and system-control instructions: next address,
// flag update, stall and sleep control towards the execute datapath.
// Assumes the fetch unit holds instr stable while stall is high.
`timescale 1ns/10ps
`include "decode_map.svh"

// Summary of operation
// - Branch-if-clear is taken only when the condition flag is 0.
// - Branch-if-set is taken only when the condition flag is 1.
// - Subroutine return resumes at the address saved by the call.
// - Exception return resumes the interrupted program flow.
// - Sleep enters the power-down state.
// - Prefetch requests a cache fill and writes no general register.
// - Separate decodes for loading control and system registers.
// - Decode for copying a control register to a general register.
// - Decode for copying a system register to a general register.
// - Register fields are binary indices; 0000 is R0, 0001 is R1.
// - Cycle counts are minimums, valid without memory wait states.
// - Fetch and data access contention adds stall cycles.
// - A read of the register just loaded from memory stalls.
// - Displacements always scale by 2, as words; the byte and long shifts are never selected.
// - Instructions marked no-change leave the condition flag as is.
module branch_sysctl_decode
  import decode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the fetch unit
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] pc,
  input wire logic fetch_data_conflict,
  input wire logic mem_wait,
  input wire logic wake,
  // From the execute datapath
  input wire logic [31:0] reg_value,
  input wire logic [31:0] saved_exc_pc,
  input wire logic load_in_flight,
  input wire logic [3:0] load_dst_idx,
  // To the fetch unit and execute datapath
  output logic stall,
  output logic branch_taken,
  output logic [31:0] branch_target,
  output logic exc_return,
  output logic sleeping,
  output logic prefetch_req,
  output logic [31:0] prefetch_addr,
  output logic ctrl_load,
  output logic sys_load,
  output logic ctrl_store,
  output logic sys_store,
  output logic [3:0] reg_idx,
  output logic flag,
  output logic [31:0] return_addr
);

  typedef struct packed {
    issue_state_t state;
    logic [2:0] cycles;
    logic stall;
    logic branch_taken;
    logic [31:0] branch_target;
    logic exc_return;
    logic sleeping;
    logic prefetch_req;
    logic [31:0] prefetch_addr;
    logic ctrl_load;
    logic sys_load;
    logic ctrl_store;
    logic sys_store;
    logic [3:0] reg_idx;
    logic flag;
    logic [31:0] return_addr;
  } issue_regs_t;

  issue_regs_t r;
  issue_regs_t next_r;
  decode_if dec ();
  logic hazard;
  logic issue;
  logic [31:0] rel_target;
  logic [2:0] min_cycles;

  field_decode u_field_decode (
    .instr(instr),
    .dec(dec)
  );

  //////////////////////////////////////////////////////////////////////////
  // Hazards
  // Stall on a read of the register a pending load writes
  assign hazard = fetch_data_conflict || mem_wait ||
    (load_in_flight && dec.reads_src &&
     load_dst_idx == dec.src_idx);
  assign issue = instr_valid && !hazard && r.state == st_run &&
    r.cycles == 3'd0;
  assign rel_target = pc + 32'd4 + dec.disp_scaled;

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r = r;
    next_r.branch_taken = 1'b0;
    next_r.exc_return = 1'b0;
    next_r.prefetch_req = 1'b0;
    next_r.ctrl_load = 1'b0;
    next_r.sys_load = 1'b0;
    next_r.ctrl_store = 1'b0;
    next_r.sys_store = 1'b0;
    min_cycles = `CYC_ONE;
    if (r.cycles != 3'd0) begin
      next_r.cycles = r.cycles - 3'd1;
    end
    case (r.state)
      st_run: begin
        if (instr_valid && hazard) begin
          next_r.state = st_stall;
        end else if (issue) begin
          next_r.reg_idx = dec.src_idx;
          case (dec.op)
            op_branch_if_flag_clear: begin
              if (r.flag == 1'b0) begin
                next_r.branch_taken = 1'b1;
                next_r.branch_target = rel_target;
                min_cycles = `CYC_BRANCH_TAKEN;
              end
            end
            op_branch_if_flag_set: begin
              if (r.flag == 1'b1) begin
                next_r.branch_taken = 1'b1;
                next_r.branch_target = rel_target;
                min_cycles = `CYC_BRANCH_TAKEN;
              end
            end
            op_branch, op_branch_sub: begin
              next_r.branch_taken = 1'b1;
              next_r.branch_target = rel_target;
              min_cycles = `CYC_BRANCH_DLY;
              if (dec.op == op_branch_sub) begin
                next_r.return_addr = pc + 32'd4;
              end
            end
            op_branch_far, op_branch_sub_far: begin
              next_r.branch_taken = 1'b1;
              next_r.branch_target = pc + 32'd4 + reg_value;
              min_cycles = `CYC_BRANCH_DLY;
              if (dec.op == op_branch_sub_far) begin
                next_r.return_addr = pc + 32'd4;
              end
            end
            op_jump, op_jump_sub: begin
              next_r.branch_taken = 1'b1;
              next_r.branch_target = reg_value;
              min_cycles = `CYC_BRANCH_DLY;
              if (dec.op == op_jump_sub) begin
                next_r.return_addr = pc + 32'd4;
              end
            end
            op_sub_return: begin
              next_r.branch_taken = 1'b1;
              next_r.branch_target = r.return_addr;
              min_cycles = `CYC_BRANCH_DLY;
            end
            op_exception_return: begin
              next_r.exc_return = 1'b1;
              next_r.branch_taken = 1'b1;
              next_r.branch_target = saved_exc_pc;
              min_cycles = `CYC_EXC_RETURN;
            end
            op_sleep: begin
              next_r.state = st_sleep;
              min_cycles = `CYC_SLEEP;
            end
            op_cache_prefetch_instr: begin
              // No register write strobe is raised here
              next_r.prefetch_req = 1'b1;
              next_r.prefetch_addr = reg_value;
            end
            op_load_control_reg_instr: next_r.ctrl_load = 1'b1;
            op_load_system_reg_instr: next_r.sys_load = 1'b1;
            op_store_control_reg_instr: next_r.ctrl_store = 1'b1;
            op_store_system_reg_instr: next_r.sys_store = 1'b1;
            op_clear_flag: next_r.flag = 1'b0;
            op_set_flag: next_r.flag = 1'b1;
            default: next_r.flag = r.flag;
          endcase
          // Extra cycles beyond the first hold off the next issue
          next_r.cycles = min_cycles - 3'd1;
        end
      end
      st_stall: begin
        if (!hazard) begin
          next_r.state = st_run;
        end
      end
      st_sleep: begin
        if (wake) begin
          next_r.state = st_run;
        end
      end
      default: next_r.state = st_run;
    endcase
    next_r.sleeping = next_r.state == st_sleep;
    next_r.stall = next_r.state != st_run || next_r.cycles != 3'd0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.state <= st_run;
      r.flag <= `RESET_FLAG;
      r.return_addr <= `RESET_ADDR;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign stall = r.stall;
  assign branch_taken = r.branch_taken;
  assign branch_target = r.branch_target;
  assign exc_return = r.exc_return;
  assign sleeping = r.sleeping;
  assign prefetch_req = r.prefetch_req;
  assign prefetch_addr = r.prefetch_addr;
  assign ctrl_load = r.ctrl_load;
  assign sys_load = r.sys_load;
  assign ctrl_store = r.ctrl_store;
  assign sys_store = r.sys_store;
  assign reg_idx = r.reg_idx;
  assign flag = r.flag;
  assign return_addr = r.return_addr;

endmodule

// file: sim/branch_sysctl_decode_checker.sv
// Assertions on the decoder's top ports.
// Assumes one core clock and the active-high reset.
`timescale 1ns/10ps
module branch_sysctl_decode_checker
  import decode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] pc,
  input wire logic fetch_data_conflict,
  input wire logic mem_wait,
  input wire logic [31:0] reg_value,
  input wire logic load_in_flight,
  input wire logic [3:0] load_dst_idx,
  // Outputs
  input wire logic stall,
  input wire logic branch_taken,
  input wire logic [31:0] branch_target,
  input wire logic exc_return,
  input wire logic sleeping,
  input wire logic prefetch_req,
  input wire logic [31:0] prefetch_addr,
  input wire logic [3:0] reg_idx,
  input wire logic flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic go;
  logic haz;
  logic cache_prefetch_instr;
  logic flag_op;
  assign go = instr_valid && !stall && !fetch_data_conflict && !mem_wait;
  assign haz = load_in_flight && load_dst_idx == instr[11:8];
  assign cache_prefetch_instr = instr[15:12] == 4'h0 && instr[7:0] == 8'h83;
  // Flag may only move the cycle after a flag set or clear issues
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_op <= 1'b0;
    end else begin
      flag_op <= go && (instr == 16'h0008 || instr == 16'h0018);
    end
  end
  ////////////////////////////////////////
  AST_BR_CLEAR: assert property (
    go && instr[15:8] == 8'h8b && !flag |=> branch_taken && stall
    ##1 !branch_taken && stall ##1 !stall)
    else $error("taken branch-if-clear timing wrong");
  AST_BR_SET: assert property (
    go && instr[15:8] == 8'h89 && !flag |=> !branch_taken && !stall)
    else $error("branch-if-set taken with flag clear");
  AST_TARGET: assert property (
    go && instr[15:8] == 8'h8d && flag |=> branch_target == $past(pc)
    + 32'd4 + {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
    else $error("branch target scaling wrong");
  AST_EXC: assert property (
    go && instr == 16'h002b |=> exc_return && stall ##1 stall[*3] ##1 !stall)
    else $error("exception return timing wrong");
  AST_SLEEP: assert property (
    go && instr == 16'h001b |=> sleeping && stall)
    else $error("sleep not entered");
  AST_CACHE_PREFETCH_INSTR: assert property (
    go && !haz && cache_prefetch_instr |=> prefetch_req && prefetch_addr == $past(reg_value)
    && reg_idx == $past(instr[11:8]))
    else $error("prefetch request wrong");
  AST_HAZ: assert property (
    instr_valid && !stall && haz && cache_prefetch_instr |=> stall && !prefetch_req)
    else $error("load-use hazard not stalled");
  AST_CONFLICT: assert property (
    instr_valid && fetch_data_conflict |=> stall && !branch_taken)
    else $error("contention not stalled");
  AST_FLAG: assert property ($changed(flag) |-> flag_op)
    else $error("flag moved without a flag instruction");
  COV_BRANCH: cover property (branch_taken);
  COV_SLEEP: cover property (sleeping);
  COV_CACHE_PREFETCH_INSTR: cover property (prefetch_req);
endmodule

bind branch_sysctl_decode branch_sysctl_decode_checker i_checker (
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .pc(pc),
  .fetch_data_conflict(fetch_data_conflict), .mem_wait(mem_wait),
  .reg_value(reg_value), .load_in_flight(load_in_flight),
  .load_dst_idx(load_dst_idx), .stall(stall), .branch_taken(branch_taken),
  .branch_target(branch_target), .exc_return(exc_return),
  .sleeping(sleeping), .prefetch_req(prefetch_req),
  .prefetch_addr(prefetch_addr), .reg_idx(reg_idx), .flag(flag));

// file: sim/exec_model.sv
// Execute-side model: general registers and exception resume address.
// Assumes the decoder reads the register named by instr[11:8].
`timescale 1ns/10ps
module exec_model
(
  // Word seen by the decoder
  input wire logic [15:0] instr,
  // Datapath answers
  output logic [31:0] reg_value,
  output logic [31:0] saved_exc_pc
);
  // Each register's value names its index, so a wrong select shows
  assign reg_value = {16'h4000, 12'h000, instr[11:8]};
  assign saved_exc_pc = 32'h00000800;
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the branch and system-control decoder.
// Assumes the checker is bound and the execute-side model is compiled.
`timescale 1ns/10ps
module tb_top;
  import decode_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0009;
  logic [31:0] pc = 32'h0;
  logic fetch_data_conflict = 1'b0;
  logic mem_wait = 1'b0;
  logic wake = 1'b0;
  logic load_in_flight = 1'b0;
  logic [3:0] load_dst_idx = 4'h0;
  logic [31:0] reg_value;
  logic [31:0] saved_exc_pc;
  logic [31:0] branch_target;
  logic [31:0] prefetch_addr;
  logic [31:0] return_addr;
  logic stall, branch_taken, exc_return, sleeping, prefetch_req, flag;
  logic ctrl_load, sys_load, ctrl_store, sys_store;
  logic [3:0] reg_idx;
  int mismatches = 0;
  int check_count = 0;

  always #25 clk = ~clk;

  exec_model i_exec_model (.instr(instr), .reg_value(reg_value),
    .saved_exc_pc(saved_exc_pc));
  branch_sysctl_decode i_branch_sysctl_decode (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .pc(pc),
    .fetch_data_conflict(fetch_data_conflict), .mem_wait(mem_wait),
    .wake(wake), .reg_value(reg_value), .saved_exc_pc(saved_exc_pc),
    .load_in_flight(load_in_flight), .load_dst_idx(load_dst_idx),
    .stall(stall), .branch_taken(branch_taken),
    .branch_target(branch_target), .exc_return(exc_return),
    .sleeping(sleeping), .prefetch_req(prefetch_req),
    .prefetch_addr(prefetch_addr), .ctrl_load(ctrl_load),
    .sys_load(sys_load), .ctrl_store(ctrl_store), .sys_store(sys_store),
    .reg_idx(reg_idx), .flag(flag), .return_addr(return_addr));
  ////////////////////////////////////////
  task automatic chk_word(string name, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  // Word stays offered until an edge with stall low takes it
  task automatic accept;
    int n;
    n = 0;
    @(negedge clk);
    while (stall !== 1'b0 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) chk_word("stall released", 32'h0, {31'h0, stall});
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic issue(logic [15:0] w, logic [31:0] a);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    pc <= a;
    accept;
  endtask

  task automatic stall_len(output int n);
    n = 0;
    while (stall === 1'b1 && n < 10) begin
      n++;
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_cond;
    logic [7:0] ops [4] = '{8'h8b, 8'h89, 8'h8f, 8'h8d};
    logic [31:0] a;
    logic tk;
    int n;
    // Set first, so that the later clear is seen to act
    for (int f = 1; f >= 0; f--) begin
      issue(f ? 16'h0018 : 16'h0008, 32'h0);
      chk_word("flag", 32'(f), {31'h0, flag});
      for (int k = 0; k < 4; k++) begin
        a = 32'h200 + 32'(k * 16);
        tk = k[0] ? f[0] : !f[0];
        issue({ops[k], 8'h05}, a);
        chk_word("taken", {31'h0, tk},
          {31'h0, branch_taken});
        if (tk) chk_word("target", a + 32'd14, branch_target);
        stall_len(n);
        chk_word("stall cycles", tk ? 32'd2 : 32'd0, 32'(n));
        chk_word("flag kept", 32'(f), {31'h0, flag});
      end
    end
  endtask

  task automatic t_call;
    int n;
    issue(16'hb004, 32'h100);
    chk_word("return_addr", 32'h104, return_addr);
    chk_word("call target", 32'h10c, branch_target);
    stall_len(n);
    chk_word("call stall cycles", 32'd1, 32'(n));
    issue(16'h000b, 32'h10c);
    chk_word("return taken", 32'h1, {31'h0, branch_taken});
    chk_word("return target", 32'h104, branch_target);
    stall_len(n);
    // Register jump through R10; its model value names the index
    issue(16'h4a2b, 32'h600);
    chk_word("jump target", 32'h4000000a, branch_target);
    stall_len(n);
  endtask

  task automatic t_exc;
    int n;
    issue(16'h002b, 32'h300);
    chk_word("exc_return", 32'h1, {31'h0, exc_return});
    chk_word("exc target", 32'h800, branch_target);
    stall_len(n);
    chk_word("exc stall cycles", 32'd4, 32'(n));
  endtask

  task automatic t_sleep;
    issue(16'h001b, 32'h400);
    repeat (5) @(negedge clk);
    chk_word("asleep", 32'h3, {30'h0, sleeping, stall});
    @(posedge clk);
    wake <= 1'b1;
    repeat (3) @(negedge clk);
    chk_word("awake", 32'h0, {31'h0, sleeping});
    @(posedge clk);
    wake <= 1'b0;
  endtask

  task automatic t_sys;
    logic [15:0] base [5] = '{16'h0083, 16'h400e, 16'h400a, 16'h0002,
      16'h000a};
    logic [3:0] idx [3] = '{4'h0, 4'h1, 4'hf};
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 3; j++) begin
        issue(base[k] | {4'h0, idx[j], 8'h00}, 32'h500);
        chk_word("pulses", 32'h10 >> k,
          {27'h0, prefetch_req, ctrl_load, sys_load, ctrl_store, sys_store});
        chk_word("reg_idx", {28'h0, idx[j]},
          {28'h0, reg_idx});
        if (k == 0) chk_word("pf addr",
          {28'h4000000, idx[j]}, prefetch_addr);
      end
    end
  endtask

  // Hazard, contention and wait state each hold off a prefetch
  task automatic t_hold(int sel);
    @(posedge clk);
    load_in_flight <= (sel == 0);
    load_dst_idx <= 4'h3;
    fetch_data_conflict <= (sel == 1);
    mem_wait <= (sel == 2);
    instr_valid <= 1'b1;
    instr <= 16'h0383;
    @(posedge clk);
    repeat (2) begin
      @(negedge clk);
      chk_word("held", 32'h2, {30'h0, stall, prefetch_req});
    end
    @(posedge clk);
    load_in_flight <= 1'b0;
    fetch_data_conflict <= 1'b0;
    mem_wait <= 1'b0;
    accept;
    chk_word("released", 32'h1, {31'h0, prefetch_req});
  endtask
  ////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_word("reset outputs", 32'h0,
      {28'h0, flag, stall, branch_taken, sleeping});
    t_cond;
    t_call;
    t_exc;
    t_sleep;
    t_sys;
    for (int s = 0; s < 3; s++) t_hold(s);
    conclude;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude;
  end
endmodule
